/* verif/gpio_pad_model.sv */
// Outside circuitry on the six pads: resolves each wire from the port and the world.
// Assumes the world always puts a level on a pin that the port has released.
`timescale 1ns/10ps
module gpio_pad_model
  import gpio_port_a_pkg::*;
(
  // Drivers
  input wire pad_drive_t padDrive,
  input wire logic [5:0] extLevel,
  // Wire levels
  output logic [5:0] padIn
);
  // Pin four only ever sinks, so an enabled driver there always reads low.
  always_comb begin
    padIn = extLevel;
    for (int i = 0; i < 6; i++)
      if (!padDrive.enableN[i]) padIn[i] = padDrive.level[i];
  end
endmodule

/* verif/gpio_port_a_properties.sv */
// Concurrent checks on the six-bit port, seeing only its top ports.
// Assumes one clock domain and the analog map handed on by the bind.
`timescale 1ns/10ps
module gpio_port_a_checker
  import gpio_port_a_pkg::*;
#(
  parameter logic [7:0][5:0] ANALOG_MAP = ANALOG_MAP_DEFAULT
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Register port
  input wire reg_req_t regReq,
  input wire logic [7:0] rdata,
  // Pads and peripherals
  input wire logic [5:0] padIn,
  input wire pad_drive_t padDrive,
  input wire logic timerClockEnable,
  input wire logic slaveSelectEnable,
  input wire peripheral_link_t periph
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // The synchroniser flops start at zero, so pad tracking is judged only once they are filled.
  logic [2:0] age;
  logic [2:0] next_age;
  always_comb next_age = (age == 3'h4) ? age : age + 3'h1;
  always_ff @(posedge clk or negedge nrst) if (!nrst) age <= 3'h0; else age <= next_age;
  sequence lone_wr(a);
    regReq.write && regReq.addr == a ##1 !(regReq.write && regReq.addr == a);
  endsequence
  open_drain_a: assert property (padDrive.level[4] == 1'b0)
    else $error("pin four driven high");
  latch_drive_a: assert property (lone_wr(8'h05) |=> padDrive.level == ($past(regReq.wdata[5:0], 2) & 6'h2F))
    else $error("pad level does not follow latch");
  dir_release_a: assert property (lone_wr(8'h85) |=> padDrive.enableN[3:0] == $past(regReq.wdata[3:0], 2))
    else $error("enable does not follow direction");
  timer_owns_a: assert property (timerClockEnable [*2] |=> padDrive.enableN[4])
    else $error("timer pin still driven");
  ss_owns_a: assert property (slaveSelectEnable [*2] |=> padDrive.enableN[5])
    else $error("select pin still driven");
  idle_read_a: assert property (!regReq.read |=> rdata == 8'h00)
    else $error("read data outside its cycle");
  upper_zero_a: assert property (regReq.read |=> rdata[7:6] == 2'h0)
    else $error("upper bits not zero");
  analog_zero_a: assert property (regReq.read && regReq.addr == 8'h05 ##1 $stable(periph.analogSelect)
    |-> (rdata[5:0] & periph.analogSelect) == 6'h00) else $error("analog pin reads one");
  map_decode_a: assert property (lone_wr(8'h9F) |=> periph.analogSelect == ANALOG_MAP[$past(regReq.wdata[2:0], 2)])
    else $error("analog select mismatch");
  timer_sync_a: assert property (age == 3'h4 |-> periph.timerExternalClock == $past(padIn[4], 3))
    else $error("timer clock not three edges behind pad");
  ss_analog_a: assert property (periph.analogSelect[5] |-> periph.slaveSelectN)
    else $error("select active on analog pin");
  cover property (lone_wr(8'h9F));
  cover property (timerClockEnable [*2]);
  cover property (regReq.read && regReq.addr == 8'h05);
endmodule
bind gpio_port_a gpio_port_a_checker #(.ANALOG_MAP(ANALOG_MAP)) u_checker (.clk(clk), .nrst(nrst),
  .regReq(regReq), .rdata(rdata), .padIn(padIn), .padDrive(padDrive), .timerClockEnable(timerClockEnable),
  .slaveSelectEnable(slaveSelectEnable), .periph(periph));

/* verif/test_gpio_port_a.sv */
// Self-checking bench for the six-bit port against an integer reference model.
// Assumes the pad model closes the loop and the checker is bound to the port.
`timescale 1ns/10ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin fails++; $display("ERROR %s exp %h got %h", n, e, g); end end
module test_gpio_port_a
  import gpio_port_a_pkg::*;
;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  reg_req_t regReq = '0;
  logic [7:0] rdata;
  logic [5:0] padIn;
  logic [5:0] ext = 6'h15;
  pad_drive_t padDrive;
  logic timerClockEnable = 1'b0;
  logic slaveSelectEnable = 1'b0;
  peripheral_link_t periph;
  int fails = 0;
  int total_checks = 0;
  int dir = 'h3F;
  int latch = 0;
  int cfg = 0;
  logic [7:0] got;
  logic [7:0] w;
  always #5 clk = ~clk;
  gpio_port_a u_dut (.clk(clk), .nrst(nrst), .regReq(regReq), .rdata(rdata), .padIn(padIn),
    .padDrive(padDrive), .timerClockEnable(timerClockEnable), .slaveSelectEnable(slaveSelectEnable), .periph(periph));
  gpio_pad_model u_pads (.padDrive(padDrive), .extLevel(ext), .padIn(padIn));
  ////////////////////////////////////////////////////////////////
  function automatic logic [5:0] drv();
    return ~(dir[5:0] | {slaveSelectEnable, timerClockEnable, 4'h0} | (latch[5:0] & 6'h10));
  endfunction
  function automatic logic [5:0] raw();
    return (drv() & latch[5:0]) | (~drv() & ext);
  endfunction
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    regReq <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    regReq.write <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    regReq <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk);
    regReq.read <= 1'b0;
    @(negedge clk);
    d = rdata;
    @(posedge clk);
  endtask
  task automatic check_all();
    logic [5:0] r;
    logic [5:0] m;
    r = raw();
    m = ANALOG_MAP_DEFAULT[cfg];
    rd(8'h05, got); `CHK("data", {2'h0, r & ~m}, got)
    rd(8'h85, got); `CHK("direction", {2'h0, dir[5:0]}, got)
    rd(8'h9F, got); `CHK("config", {5'h00, cfg[2:0]}, got)
    `CHK("enables", ~drv(), padDrive.enableN)
    `CHK("level", latch[5:0] & 6'h2F, padDrive.level)
    `CHK("analog", m, periph.analogSelect)
    `CHK("reference", REFERENCE_MAP_DEFAULT[cfg] & m[3], periph.referenceSelect)
    `CHK("timer clock", r[4], periph.timerExternalClock)
    `CHK("select", m[5] | r[5], periph.slaveSelectN)
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    #100us;
    fails++;
    print_verdict();
  end
  initial begin
    void'($urandom(93));
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    check_all();
    wr(8'h10, 8'hFF);
    rd(8'h10, got); `CHK("unmapped", 8'h00, got)
    rd(8'h46, got); `CHK("clear port", 8'h00, got)
    for (int i = 0; i < 64; i++) begin
      w = 8'($urandom);
      case (i % 4)
        0: begin
          slaveSelectEnable <= 1'b0;
          cfg = (i / 4) % 8;
          wr(8'h9F, {w[7:3], cfg[2:0]});
        end
        1: begin
          dir = w[5:0] | ANALOG_MAP_DEFAULT[cfg];
          wr(8'h85, w | {2'h0, ANALOG_MAP_DEFAULT[cfg]});
        end
        2: begin
          latch = w[5:0];
          wr(8'h05, w);
        end
        default: begin
          latch = w[0] ? (raw() & ~ANALOG_MAP_DEFAULT[cfg]) | w[5:0] : raw() & ~ANALOG_MAP_DEFAULT[cfg] & ~w[5:0];
          wr(w[0] ? 8'h45 : 8'h46, w);
        end
      endcase
      timerClockEnable <= 1'($urandom);
      slaveSelectEnable <= cfg[2] & 1'($urandom);
      ext <= 6'($urandom);
      repeat (4) @(posedge clk);
      check_all();
    end
    print_verdict();
  end
endmodule

/* verilog/gpio_port_a.sv */
// Six-bit bidirectional port with direction register, output latch and analog pin selection.
// Assumes a single-cycle register port with read data one cycle after the read strobe,
// and pad cells outside that resolve level and active-low enable into the wire.
//
// Summary of operation
// - Six pins, each with a direction bit; one releases the driver, pin is input.
// - Direction bit zero drives the pin from its output latch bit.
// - Data reads return pin levels; data writes update the output latch only.
// - Set and clear writes modify the sampled pin levels and store the result into the latch.
// - Pin four feeds the timer clock input and only ever pulls low.
// - Pins zero to three and five may be analog; pin three may be reference.
// - After reset analog-capable pins are analog and read back as zero.
// - Direction bits govern drivers even in analog mode; software keeps them one.
// - Pin five also carries the serial port slave-select input.
// - Unimplemented upper bits of all three registers read back as zero.
// - A pin owned by an enabled peripheral has its driver kept off; data reads still return its level.
`timescale 1ns/10ps

module gpio_port_a
  import gpio_port_a_pkg::*;
#(
  parameter logic [7:0][5:0] ANALOG_MAP = ANALOG_MAP_DEFAULT,
  parameter logic [7:0] REFERENCE_MAP = REFERENCE_MAP_DEFAULT
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Register port
  input wire reg_req_t regReq,
  output logic [7:0] rdata,
  // Pads
  input wire logic [5:0] padIn,
  output pad_drive_t padDrive,
  // Peripheral ownership requests
  input wire logic timerClockEnable,
  input wire logic slaveSelectEnable,
  // Peripheral side
  output peripheral_link_t periph
);

  ////////////////////////////////////////////////////////////////////////////////
  // Pad input synchronisation

  logic [5:0] pinLevel;

  gpio_sync2 padSync (
    .clk(clk),
    .nrst(nrst),
    .d(padIn),
    .q(pinLevel)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Register state

  logic [5:0] dataLatch;
  logic [5:0] direction;
  logic [2:0] analogSelectField;
  logic [5:0] next_dataLatch;
  logic [5:0] next_direction;
  logic [2:0] next_analogSelectField;

  logic [5:0] analogMask;
  logic [5:0] digitalLevel;
  latch_op_t latchOp;

  // The decode is kept in a table so that a derivative with a different pin map
  // only changes parameters; pin four can never be analog whatever the table says.
  always_comb begin
    analogMask = ANALOG_MAP[analogSelectField] & ANALOG_CAPABLE_MASK;
  end

  // Analog pins have their digital input buffer off, so they read as zero.
  always_comb begin
    digitalLevel = pinLevel & ~analogMask;
  end

  always_comb begin
    latchOp = regReq.write ? decodeLatchOp(regReq.addr) : OP_NONE;
  end

  // Set and clear updates start from the pins as they are seen now, so bits that a
  // set or clear does not touch pick up the pin level, not the old latch value.
  // A plain load replaces all six bits and so loses nothing to that sampling.
  always_comb begin
    next_dataLatch = dataLatch;
    case (latchOp)
      OP_LOAD: next_dataLatch = regReq.wdata[5:0];
      OP_SET: next_dataLatch = digitalLevel | regReq.wdata[5:0];
      OP_CLEAR: next_dataLatch = digitalLevel & ~regReq.wdata[5:0];
      OP_NONE: next_dataLatch = dataLatch;
      default: next_dataLatch = dataLatch;
    endcase
  end

  always_comb begin
    next_direction = direction;
    if (regReq.write && (regReq.addr == PORT_A_DIRECTION_ADDR)) begin
      next_direction = regReq.wdata[5:0];
    end
  end

  always_comb begin
    next_analogSelectField = analogSelectField;
    if (regReq.write && (regReq.addr == ANALOG_PIN_CONFIG_ADDR)) begin
      next_analogSelectField = regReq.wdata[ANALOG_FIELD_LSB +: ANALOG_FIELD_WIDTH];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dataLatch <= DATA_LATCH_RESET;
      direction <= DIRECTION_RESET;
      analogSelectField <= ANALOG_CONFIG_RESET;
    end else begin
      dataLatch <= next_dataLatch;
      direction <= next_direction;
      analogSelectField <= next_analogSelectField;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read data

  logic [7:0] next_rdata;

  // Unmapped addresses and the set and clear aliases read as zero.
  always_comb begin
    next_rdata = READ_DATA_RESET;
    if (regReq.read) begin
      case (regReq.addr)
        PORT_A_DATA_ADDR: next_rdata = padByte(digitalLevel);
        PORT_A_DIRECTION_ADDR: next_rdata = padByte(direction);
        ANALOG_PIN_CONFIG_ADDR: next_rdata = {5'h00, analogSelectField};
        default: next_rdata = READ_DATA_RESET;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata <= READ_DATA_RESET;
    end else begin
      rdata <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pad drivers

  logic [5:0] ownedByPeripheral;
  logic [5:0] driving;
  pad_drive_t next_padDrive;

  // Both shared peripheral functions here are inputs, so owning a pin means
  // keeping its driver off even if the direction bit was left at zero.
  always_comb begin
    ownedByPeripheral = 6'h00;
    ownedByPeripheral[TIMER_CLOCK_PIN] = timerClockEnable;
    ownedByPeripheral[SLAVE_SELECT_PIN] = slaveSelectEnable;
  end

  // The analog mask plays no part here: direction and peripheral ownership govern the drivers,
  // so a pin left as output in analog mode will fight the analog source.
  always_comb begin
    driving = ~direction & ~ownedByPeripheral;
  end

  always_comb begin
    next_padDrive.level = dataLatch;
    next_padDrive.enableN = ~driving;
    // Open drain: the level is always low and the driver is on only for a zero.
    next_padDrive.level[TIMER_CLOCK_PIN] = 1'b0;
    next_padDrive.enableN[TIMER_CLOCK_PIN] = ~(driving[TIMER_CLOCK_PIN] && !dataLatch[TIMER_CLOCK_PIN]);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      padDrive.level <= 6'h00;
      padDrive.enableN <= 6'h3F;
    end else begin
      padDrive <= next_padDrive;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Peripheral side

  peripheral_link_t next_periph;

  // The slave-select input is idle high while its pin is analog, since the
  // digital buffer is off then; this is why those analog codes must be avoided.
  always_comb begin
    next_periph.analogSelect = analogMask;
    next_periph.referenceSelect = REFERENCE_MAP[analogSelectField] && analogMask[REFERENCE_PIN];
    next_periph.timerExternalClock = pinLevel[TIMER_CLOCK_PIN];
    next_periph.slaveSelectN = analogMask[SLAVE_SELECT_PIN] ? 1'b1 : pinLevel[SLAVE_SELECT_PIN];
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      periph.analogSelect <= ANALOG_CAPABLE_MASK;
      periph.referenceSelect <= 1'b0;
      periph.timerExternalClock <= 1'b0;
      periph.slaveSelectN <= 1'b1;
    end else begin
      periph <= next_periph;
    end
  end

endmodule

/* verilog/gpio_port_a_pkg.sv */
// Constants, types and helpers shared by the six-bit general-purpose port.
// Assumes a byte-wide register port with 8-bit addresses and a single core clock.
package gpio_port_a_pkg;

  localparam int PIN_COUNT = 6;

  // Register addresses on the plain register port.
  localparam logic [7:0] PORT_A_DATA_ADDR = 8'h05;
  localparam logic [7:0] PORT_A_DIRECTION_ADDR = 8'h85;
  localparam logic [7:0] ANALOG_PIN_CONFIG_ADDR = 8'h9F;
  localparam logic [7:0] PORT_A_SET_ADDR = 8'h45;
  localparam logic [7:0] PORT_A_CLEAR_ADDR = 8'h46;

  // Values after reset.
  localparam logic [5:0] DATA_LATCH_RESET = 6'h00;
  localparam logic [5:0] DIRECTION_RESET = 6'h3F;
  localparam logic [2:0] ANALOG_CONFIG_RESET = 3'h0;
  localparam logic [7:0] READ_DATA_RESET = 8'h00;

  // Field positions and pin roles.
  localparam int ANALOG_FIELD_LSB = 0;
  localparam int ANALOG_FIELD_WIDTH = 3;
  localparam int TIMER_CLOCK_PIN = 4;
  localparam int SLAVE_SELECT_PIN = 5;
  localparam int REFERENCE_PIN = 3;
  localparam logic [5:0] ANALOG_CAPABLE_MASK = 6'h2F;

  // Default decode of the analog select field: one analog mask per code.
  localparam logic [7:0][5:0] ANALOG_MAP_DEFAULT = {
    6'h00, 6'h00, 6'h0B, 6'h0B, 6'h2F, 6'h2F, 6'h2F, 6'h2F
  };
  // Codes in which the reference pin carries the analog reference.
  localparam logic [7:0] REFERENCE_MAP_DEFAULT = 8'h2A;

  typedef enum logic [1:0] {
    OP_NONE = 2'b00,
    OP_LOAD = 2'b01,
    OP_SET = 2'b10,
    OP_CLEAR = 2'b11
  } latch_op_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic write;
    logic read;
  } reg_req_t;

  typedef struct packed {
    logic [5:0] level;
    logic [5:0] enableN;
  } pad_drive_t;

  typedef struct packed {
    logic [5:0] analogSelect;
    logic referenceSelect;
    logic timerExternalClock;
    logic slaveSelectN;
  } peripheral_link_t;

  // Which latch operation a write to this address asks for.
  function automatic latch_op_t decodeLatchOp(input logic [7:0] addr);
    latch_op_t op;
    op = OP_NONE;
    case (addr)
      PORT_A_DATA_ADDR: op = OP_LOAD;
      PORT_A_SET_ADDR: op = OP_SET;
      PORT_A_CLEAR_ADDR: op = OP_CLEAR;
      default: op = OP_NONE;
    endcase
    return op;
  endfunction

  // Place a six-bit value in the low bits of a byte; the upper bits read as zero.
  function automatic logic [7:0] padByte(input logic [5:0] value);
    return {2'h0, value};
  endfunction

endpackage

/* verilog/gpio_sync2.sv */
// Two-stage synchroniser for the six pad input levels.
// Assumes the pads are asynchronous to clk; only the second stage is read outside.
`timescale 1ns/10ps

module gpio_sync2
  import gpio_port_a_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Levels
  input wire logic [5:0] d,
  output logic [5:0] q
);

  logic [5:0] stage1;
  logic [5:0] next_stage1;
  logic [5:0] next_q;

  always_comb begin
    next_stage1 = d;
    next_q = stage1;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stage1 <= 6'h00;
      q <= 6'h00;
    end else begin
      stage1 <= next_stage1;
      q <= next_q;
    end
  end

endmodule
